/* File: ssc_top.sv */
// Signature memory store/compare controller with AXI4-Lite register slave.
// Assumes an asynchronous word-wide memory module on pins and a same-clock measurement engine.
`timescale 1ns/1ps
module ssc_top #(
   parameter int SHOW_N = ssc_pkg::SHOW_CYC,
   parameter int BLINK_N = ssc_pkg::BLINK_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic sig_valid,
   input wire logic [15:0] sig_value,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_wp,
   output logic [7:0] mem_addr,
   output logic [15:0] mem_wdata,
   output logic mem_wr,
   output logic mem_rd,
   output logic beep_one,
   output logic beep_two,
   output logic err_ind,
   output logic store_sym,
   output logic hold_blink,
   output logic rcl_dots,
   output logic mem_mode,
   output logic [15:0] disp_sig,
   output logic [16*ssc_pkg::NSET-1:0] trig_set
);
   import ssc_pkg::*;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   ssc_state_t st_q;
   logic [7:0] addr_q, ptr_q, wa_q, loc_w, sig_addr_w;
   logic [3:0] cnt_q;
   logic [15:0] sig_q, rdat_s, wd_w, wmask_w;
   logic [15:0] set_q [NSET];
   logic [31:0] wd_q, stat_w, rmux_w;
   logic [3:0] ws_q;
   logic hold_q, rcl_q, ok_pulse_q, wp_s, wr_go, full_w, rd_done, wr_done;
   logic cmd_wr, set_wr, set_rd_hit, rd_hit, is_rd, is_wr;
   logic c_store, c_onoff, c_up, c_dn, c_mid, meas_go;
   logic [2:0] set_wi, set_ri;
   logic [31:0] ok_cnt_q, blink_cnt_q;

   ssc_sync #(.W(17)) u_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .d({mem_wp, mem_rdata}),
      .q({wp_s, rdat_s})
   );

   // Register bus: write address and data are taken in either order
   assign wr_go = !s_awready && !s_wready && !s_bvalid;
   assign set_wi = 3'((wa_q - R_SET0) >> 2);
   assign set_wr = wa_q >= R_SET0 && set_wi < 3'(NSET) && wa_q[1:0] == 2'b00;
   assign cmd_wr = wr_go && wa_q == R_CMD && ws_q[0];
   assign wmask_w = {{8{ws_q[1]}}, {8{ws_q[0]}}};
   assign c_store = cmd_wr && wd_q[C_STORE];
   assign c_onoff = cmd_wr && wd_q[C_ONOFF];
   assign c_up = cmd_wr && wd_q[C_UP];
   assign c_dn = cmd_wr && wd_q[C_DN];
   assign c_mid = cmd_wr && wd_q[C_MID];

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_awready <= 1'b1;
         s_wready <= 1'b1;
         s_bvalid <= 1'b0;
         s_bresp <= RESP_OKAY;
         wa_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
      end else begin
         if (s_awvalid && s_awready) begin
            s_awready <= 1'b0;
            wa_q <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            s_wready <= 1'b0;
            wd_q <= s_wdata;
            ws_q <= s_wstrb;
         end
         if (wr_go) begin
            s_bvalid <= 1'b1;
            s_bresp <= (wa_q == R_CMD || wa_q == R_CTRL || set_wr) ? RESP_OKAY : RESP_DECERR;
         end
         if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_q <= 1'b0;
      end else if (wr_go && wa_q == R_CTRL && ws_q[0]) begin
         hold_q <= wd_q[CT_HOLD];
      end
   end

   // Read side
   assign set_ri = 3'((s_araddr - R_SET0) >> 2);
   assign set_rd_hit = s_araddr >= R_SET0 && set_ri < 3'(NSET) && s_araddr[1:0] == 2'b00;
   assign full_w = ptr_q > NSIG;
   always_comb begin
      stat_w = 32'h0000_0000;
      stat_w[ST_MEM] = mem_mode;
      stat_w[ST_RCL] = rcl_q;
      stat_w[ST_BUSY] = st_q != S_IDLE;
      stat_w[ST_FULL] = full_w;
      stat_w[ST_ERR] = err_ind;
      stat_w[ST_OK] = store_sym;
      stat_w[ST_PTR +: 8] = ptr_q;
   end
   assign rd_hit = s_araddr == R_CTRL || s_araddr == R_STAT || s_araddr == R_DISP || set_rd_hit;
   assign rmux_w = s_araddr == R_CTRL ? {31'h0, hold_q} :
                   s_araddr == R_STAT ? stat_w :
                   s_araddr == R_DISP ? {16'h0000, disp_sig} :
                   set_rd_hit ? {16'h0000, set_q[set_ri]} : 32'h0000_0000;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_arready <= 1'b1;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b1;
         s_rdata <= rmux_w;
         s_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
         s_arready <= 1'b1;
      end
   end

   // Memory access sequencing
   assign is_rd = st_q == S_TBRD || st_q == S_LOAD || st_q == S_SCAN || st_q == S_RB || st_q == S_RCL;
   assign is_wr = st_q == S_WR || st_q == S_TBWR;
   assign rd_done = is_rd && cnt_q == RD_WAIT;
   assign wr_done = is_wr && cnt_q == WR_CYC;
   assign sig_addr_w = A_SIG + ptr_q - 8'h01;
   assign wd_w = st_q == S_TBWR ? TESTBYTE : addr_q < A_SIG ? set_q[3'(addr_q - A_SET)] : sig_q;
   assign loc_w = !rcl_q ? (c_up ? 8'h01 : NSIG) :
                  c_up ? (ptr_q > 8'h01 ? ptr_q - 8'h01 : ptr_q) :
                  (ptr_q < NSIG ? ptr_q + 8'h01 : ptr_q);
   assign meas_go = st_q == S_IDLE && !cmd_wr && sig_valid;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_addr <= 8'h00;
         mem_wdata <= 16'h0000;
         mem_wr <= 1'b0;
         mem_rd <= 1'b0;
      end else begin
         mem_addr <= addr_q;
         mem_wdata <= wd_w;
         mem_wr <= is_wr && !wr_done;
         mem_rd <= is_rd && !rd_done;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NSET; i++) begin
            set_q[i] <= SET_RST;
         end
      end else if (st_q == S_LOAD && rd_done) begin
         set_q[3'(addr_q - A_SET)] <= rdat_s;
      end else if (wr_go && set_wr) begin
         set_q[set_wi] <= (set_q[set_wi] & ~wmask_w) | (wd_q[15:0] & wmask_w);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= S_IDLE;
         addr_q <= A_TEST;
         cnt_q <= 4'h0;
         ptr_q <= 8'h01;
         mem_mode <= 1'b0;
         rcl_q <= 1'b0;
         sig_q <= 16'h0000;
         disp_sig <= 16'h0000;
         err_ind <= 1'b0;
         beep_one <= 1'b0;
         beep_two <= 1'b0;
         ok_pulse_q <= 1'b0;
      end else begin
         beep_one <= 1'b0;
         beep_two <= 1'b0;
         ok_pulse_q <= 1'b0;
         cnt_q <= (st_q == S_IDLE || rd_done || wr_done) ? 4'h0 : cnt_q + 4'h1;
         case (st_q)
            S_IDLE: begin
               if (c_onoff) begin
                  rcl_q <= 1'b0;
                  if (mem_mode) begin
                     mem_mode <= 1'b0;
                  end else begin
                     addr_q <= A_TEST;
                     st_q <= S_TBRD;
                  end
               end else if (mem_mode && (c_up || c_dn)) begin
                  rcl_q <= 1'b1;
                  ptr_q <= loc_w;
                  addr_q <= A_SIG + loc_w - 8'h01;
                  st_q <= S_RCL;
               end else if (rcl_q && c_mid) begin
                  rcl_q <= 1'b0;
               end else if (c_store && !mem_mode) begin
                  if (hold_q && !wp_s) begin
                     addr_q <= A_TEST;
                     st_q <= S_TBWR;
                  end
               end else if (c_store && !full_w) begin
                  if (wp_s) begin
                     beep_two <= 1'b1;
                  end else begin
                     addr_q <= ptr_q == 8'h01 ? A_SET : sig_addr_w;
                     st_q <= S_WR;
                  end
               end else if (meas_go) begin
                  sig_q <= sig_value;
                  disp_sig <= sig_value;
                  err_ind <= 1'b0;
                  if (mem_mode && !rcl_q) begin
                     if (sig_value == SIG_END) begin
                        err_ind <= 1'b1;
                        beep_two <= 1'b1;
                     end else begin
                        addr_q <= A_SIG;
                        st_q <= S_SCAN;
                     end
                  end
               end
            end
            S_TBRD: begin
               if (rd_done) begin
                  if (rdat_s == TESTBYTE) begin
                     mem_mode <= 1'b1;
                     ptr_q <= 8'h01;
                     addr_q <= A_SET;
                     st_q <= S_LOAD;
                  end else begin
                     st_q <= S_IDLE;
                  end
               end
            end
            S_LOAD: begin
               if (rd_done) begin
                  if (addr_q == A_SIG - 8'h01) begin
                     st_q <= S_IDLE;
                  end else begin
                     addr_q <= addr_q + 8'h01;
                  end
               end
            end
            S_SCAN: begin
               if (rd_done) begin
                  if (rdat_s == sig_q) begin
                     beep_one <= 1'b1;
                     st_q <= S_IDLE;
                  end else if (rdat_s == SIG_END || addr_q == A_LAST) begin
                     err_ind <= 1'b1;
                     beep_two <= 1'b1;
                     st_q <= S_IDLE;
                  end else begin
                     addr_q <= addr_q + 8'h01;
                  end
               end
            end
            S_WR: begin
               if (wr_done) begin
                  if (addr_q == sig_addr_w) begin
                     st_q <= S_RB;
                  end else begin
                     addr_q <= addr_q + 8'h01;
                  end
               end
            end
            S_RB: begin
               if (rd_done) begin
                  ptr_q <= ptr_q + 8'h01;
                  st_q <= S_IDLE;
                  if (rdat_s == sig_q) begin
                     beep_one <= 1'b1;
                     ok_pulse_q <= 1'b1;
                  end else begin
                     beep_two <= 1'b1;
                  end
               end
            end
            S_TBWR: begin
               if (wr_done) begin
                  st_q <= S_IDLE;
               end
            end
            S_RCL: begin
               if (rd_done) begin
                  disp_sig <= rdat_s;
                  st_q <= S_IDLE;
               end
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end

   // Display timers; a new store that reads back good restarts the symbol time
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ok_cnt_q <= 32'h0000_0000;
         store_sym <= 1'b0;
         blink_cnt_q <= 32'h0000_0000;
         hold_blink <= 1'b0;
      end else begin
         ok_cnt_q <= ok_pulse_q ? 32'(SHOW_N) : (ok_cnt_q != 0 ? ok_cnt_q - 32'h1 : ok_cnt_q);
         store_sym <= ok_pulse_q || ok_cnt_q > 32'h1;
         blink_cnt_q <= sig_valid ? 32'(BLINK_N) : (blink_cnt_q != 0 ? blink_cnt_q - 32'h1 : blink_cnt_q);
         hold_blink <= sig_valid || blink_cnt_q > 32'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rcl_dots <= 1'b0;
         trig_set <= '0;
      end else begin
         rcl_dots <= rcl_q;
         for (int i = 0; i < NSET; i++) begin
            trig_set[16*i +: 16] <= set_q[i];
         end
      end
   end

   sequence s_sig_written;
      st_q == S_WR && wr_done && addr_q == sig_addr_w;
   endsequence
   sequence s_rb_good;
      st_q == S_RB && rd_done && rdat_s == sig_q;
   endsequence

   a_zero_meas_err: assert property (meas_go && mem_mode && !rcl_q && sig_value == SIG_END |=> beep_two && err_ind)
      else $error("zero signature not flagged");
   a_found_one_beep: assert property (st_q == S_SCAN && rd_done && rdat_s == sig_q |=> beep_one && !beep_two)
      else $error("found signature without single beep");
   a_miss_two_beeps: assert property (st_q == S_SCAN && rd_done && rdat_s != sig_q && rdat_s == SIG_END |=> beep_two && err_ind && st_q == S_IDLE)
      else $error("terminator miss not flagged");
   a_hold_lamp: assert property (sig_valid |=> hold_blink)
      else $error("hold lamp not lit");
   a_store_readback: assert property (s_sig_written |=> st_q == S_RB && $stable(addr_q))
      else $error("store not read back at same location");
   a_store_ok_show: assert property (s_rb_good |=> beep_one ##1 store_sym[*3])
      else $error("store symbol missing after good read-back");
   a_store_bad: assert property (st_q == S_RB && rd_done && rdat_s != sig_q |=> beep_two && !ok_pulse_q)
      else $error("bad read-back not reported");
   a_full_ignored: assert property (st_q == S_IDLE && c_store && mem_mode && full_w |=> $stable(ptr_q) && !mem_wr)
      else $error("store accepted with memory full");
   a_marker_refuse: assert property (st_q == S_TBRD && rd_done && rdat_s != TESTBYTE |=> !mem_mode && st_q == S_IDLE)
      else $error("memory mode entered with bad marker");
   a_entry_ptr_one: assert property (st_q == S_TBRD && rd_done && rdat_s == TESTBYTE |=> ptr_q == 8'h01 && st_q == S_LOAD)
      else $error("pointer not reset on entry");
   a_wp_no_write: assert property (st_q == S_IDLE && c_store && mem_mode && !full_w && wp_s |=> beep_two ##1 !mem_wr)
      else $error("write attempted on protected module");
   a_recall_first: assert property (st_q == S_IDLE && mem_mode && !rcl_q && c_up && !c_onoff |=> addr_q == A_SIG ##1 rcl_dots)
      else $error("first recall not location one");
endmodule

/* File: ssc_pkg.sv */
// Constants, field positions, timing and state codes for the signature store/compare block.
// Assumes one 250 MHz clock and a word-addressed plug-in memory of 16-bit words.
package ssc_pkg;
   localparam int CLK_MHZ = 250;
   localparam int SHOW_MS = 500;
   localparam int SHOW_CYC = SHOW_MS * CLK_MHZ * 1000;
   localparam int BLINK_MS = 100;
   localparam int BLINK_CYC = BLINK_MS * CLK_MHZ * 1000;
   localparam logic [7:0] NSIG = 8'h7d;
   localparam int NSET = 5;
   localparam logic [7:0] A_TEST = 8'h00;
   localparam logic [7:0] A_SET = 8'h01;
   localparam logic [7:0] A_SIG = 8'h06;
   localparam logic [7:0] A_LAST = 8'h82;
   localparam logic [15:0] TESTBYTE = 16'h005a;
   localparam logic [15:0] SIG_END = 16'h0000;
   localparam logic [15:0] SET_RST = 16'h0000;
   localparam logic [3:0] RD_WAIT = 4'h4;
   localparam logic [3:0] WR_CYC = 4'h2;
   localparam logic [7:0] R_CMD = 8'h00;
   localparam logic [7:0] R_CTRL = 8'h04;
   localparam logic [7:0] R_SET0 = 8'h08;
   localparam logic [7:0] R_STAT = 8'h1c;
   localparam logic [7:0] R_DISP = 8'h20;
   localparam int C_STORE = 0;
   localparam int C_ONOFF = 1;
   localparam int C_UP = 2;
   localparam int C_DN = 3;
   localparam int C_MID = 4;
   localparam int CT_HOLD = 0;
   localparam int ST_MEM = 0;
   localparam int ST_RCL = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_FULL = 3;
   localparam int ST_ERR = 4;
   localparam int ST_OK = 5;
   localparam int ST_PTR = 8;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_TBRD = 3'b001,
      S_LOAD = 3'b010,
      S_SCAN = 3'b011,
      S_WR = 3'b100,
      S_RB = 3'b101,
      S_TBWR = 3'b110,
      S_RCL = 3'b111
   } ssc_state_t;
endpackage

/* File: ssc_sync.sv */
// Two-stage synchroniser for pin inputs.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ps
module ssc_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= '0;
         q <= '0;
      end else begin
         s1_q <= d;
         q <= s1_q;
      end
   end
endmodule

/* File: ssc_mem_model.sv */
// Behavioural plug-in signature memory module, word wide, read without a clock.
// Assumes the controller holds address and data steady while mem_wr is high.
`timescale 1ns/1ps
module ssc_mem_model (
   input wire logic sys_clk,
   input wire logic [7:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic mem_wp,
   input wire logic bad_rd,
   output logic [15:0] mem_rdata
);
   logic [15:0] mem [0:255];
   // New module: all cells clear, so the marker does not verify
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 16'h0000;
      end
   end
   // Jumper blocks the cells themselves, not only the controller
   always @(posedge sys_clk) begin
      if (mem_wr && !mem_wp) begin
         mem[mem_addr] <= mem_wdata;
      end
   end
   // Fault mode inverts read data so that a read-back can fail
   // Deselected pins show the inverse, so a late sample reads wrong data
   assign mem_rdata = (bad_rd || !mem_rd) ? ~mem[mem_addr] : mem[mem_addr];
endmodule

/* File: tb_top.sv */
// Self-checking bench for the signature store/compare controller.
// Assumes the behavioural memory model on the memory pins; registers reached over AXI4-Lite.
`timescale 1ns/1ps
module tb_top;
   import ssc_pkg::*;
   localparam int SHOW_T = 20;
   localparam int BLINK_T = 8;
   logic sys_clk, rst_b, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready, sig_valid, mem_wp, mem_wr, mem_rd, bad_rd;
   logic beep_one, beep_two, err_ind, store_sym, hold_blink, rcl_dots, mem_mode, blink_seen;
   logic [7:0] s_awaddr, s_araddr, mem_addr;
   logic [31:0] s_wdata, s_rdata, rd;
   logic [3:0] s_wstrb;
   logic [1:0] s_bresp, s_rresp, rsp;
   logic [15:0] sig_value, mem_rdata, mem_wdata, disp_sig;
   logic [16*NSET-1:0] trig_set;
   int miscompares = 0;
   int samples_checked = 0;
   int nb1 = 0;
   int nb2 = 0;
   int sym_cnt = 0;
   int sym_len = 0;
   int cyc = 0;
   // Row 3 is a measured 0000, row 4 lies past a stored 0000
   logic [15:0] row_sig [5] = '{16'h1234, 16'h5678, 16'h7777, 16'h0000, 16'h4321};
   logic [1:0] row_bp [5] = '{2'd1, 2'd1, 2'd2, 2'd2, 2'd2};

   ssc_top #(.SHOW_N(SHOW_T), .BLINK_N(BLINK_T)) i_ssc_top (.sys_clk(sys_clk), .rst_b(rst_b),
      .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
      .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .sig_valid(sig_valid), .sig_value(sig_value), .mem_rdata(mem_rdata),
      .mem_wp(mem_wp), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd),
      .beep_one(beep_one), .beep_two(beep_two), .err_ind(err_ind), .store_sym(store_sym),
      .hold_blink(hold_blink), .rcl_dots(rcl_dots), .mem_mode(mem_mode), .disp_sig(disp_sig),
      .trig_set(trig_set));
   ssc_mem_model i_ssc_mem_model (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wp(mem_wp), .bad_rd(bad_rd), .mem_rdata(mem_rdata));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Beeps are one-cycle pulses, so they are counted rather than polled
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (beep_one === 1'b1) nb1 = nb1 + 1;
      if (beep_two === 1'b1) nb2 = nb2 + 1;
      if (hold_blink === 1'b1) blink_seen = 1'b1;
      if (store_sym === 1'b1) begin
         sym_cnt = sym_cnt + 1;
      end else if (sym_cnt != 0) begin
         sym_len = sym_cnt;
         sym_cnt = 0;
      end
      if (cyc == 40000) begin
         miscompares++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Handshakes are judged at the falling edge, where outputs have settled
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_t, w_t, b_t;
      @(posedge sys_clk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      b_t = 1'b0;
      while (!b_t) begin
         @(negedge sys_clk);
         aw_t = s_awvalid & s_awready;
         w_t = s_wvalid & s_wready;
         b_t = s_bvalid === 1'b1;
         r = s_bresp;
         @(posedge sys_clk);
         if (aw_t) s_awvalid <= 1'b0;
         if (w_t) s_wvalid <= 1'b0;
      end
      s_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_t, r_t;
      @(posedge sys_clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      r_t = 1'b0;
      while (!r_t) begin
         @(negedge sys_clk);
         ar_t = s_arvalid & s_arready;
         r_t = s_rvalid === 1'b1;
         d = s_rdata;
         r = s_rresp;
         @(posedge sys_clk);
         if (ar_t) s_arvalid <= 1'b0;
      end
      s_rready <= 1'b0;
   endtask

   task automatic op_wait();
      repeat (3) @(posedge sys_clk);
      do begin
         axi_rd(R_STAT, rd, rsp);
      end while (rd[ST_BUSY] !== 1'b0);
   endtask

   task automatic cmd(input int b);
      nb1 = 0;
      nb2 = 0;
      sym_len = 0;
      axi_wr(R_CMD, 32'h1 << b, rsp);
      op_wait();
   endtask

   task automatic meas(input logic [15:0] v);
      nb1 = 0;
      nb2 = 0;
      blink_seen = 1'b0;
      @(posedge sys_clk);
      sig_valid <= 1'b1;
      sig_value <= v;
      @(posedge sys_clk);
      sig_valid <= 1'b0;
      op_wait();
   endtask

   task automatic tend(input string s);
      $display("test %s done", s);
   endtask

   initial begin
      rst_b = 1'b0;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, sig_valid, mem_wp, bad_rd} = 8'h00;
      s_awaddr = 8'h00;
      s_araddr = 8'h00;
      s_wdata = 32'h0;
      s_wstrb = 4'hf;
      sig_value = 16'h0000;
      repeat (8) @(posedge sys_clk);
      chk({s_awready, s_wready, s_arready, mem_mode, store_sym, rcl_dots, err_ind}, 7'b1110000);
      chk(trig_set[15:0], 16'h0000);
      rst_b <= 1'b1;
      axi_rd(R_STAT, rd, rsp);
      chk(rd[15:8], 8'h01);
      tend("reset");
      cmd(C_ONOFF);
      chk(mem_mode, 1'b0);
      axi_wr(R_CTRL, 32'h1, rsp);
      cmd(C_STORE);
      chk(i_ssc_mem_model.mem[A_TEST], TESTBYTE);
      cmd(C_ONOFF);
      chk(mem_mode, 1'b1);
      tend("marker");
      for (int i = 0; i < NSET; i++) begin
         axi_wr(8'(R_SET0 + 4 * i), 32'h1100 + i, rsp);
      end
      meas(16'h1234);
      chk(blink_seen, 1'b1);
      cmd(C_STORE);
      chk(nb1 * 4 + nb2, 4);
      chk(i_ssc_mem_model.mem[A_SIG], 16'h1234);
      repeat (SHOW_T + 5) @(posedge sys_clk);
      chk(sym_len, SHOW_T);
      for (int i = 0; i < NSET; i++) begin
         chk(i_ssc_mem_model.mem[A_SET + i], 32'h1100 + i);
      end
      axi_wr(R_SET0, 32'h2200, rsp);
      meas(16'h5678);
      cmd(C_STORE);
      chk(i_ssc_mem_model.mem[A_SIG + 1], 16'h5678);
      chk(i_ssc_mem_model.mem[A_SET], 16'h1100);
      i_ssc_mem_model.mem[A_SIG + 3] = 16'h4321;
      tend("store");
      for (int i = 0; i < 5; i++) begin
         meas(row_sig[i]);
         chk(nb1 * 4 + nb2, (row_bp[i] == 2'd1) ? 4 : 1);
         chk(err_ind, row_bp[i] == 2'd2);
         chk(disp_sig, row_sig[i]);
         chk(blink_seen, 1'b1);
      end
      tend("compare");
      bad_rd <= 1'b1;
      meas(16'h3c3c);
      cmd(C_STORE);
      chk(nb1 * 4 + nb2, 1);
      repeat (SHOW_T + 5) @(posedge sys_clk);
      chk(sym_len, 0);
      bad_rd <= 1'b0;
      // The jumper pin is synchronised, so give it time to land
      mem_wp <= 1'b1;
      repeat (4) @(posedge sys_clk);
      meas(16'h6a6a);
      cmd(C_STORE);
      chk(nb1 * 4 + nb2, 1);
      chk(i_ssc_mem_model.mem[A_SIG + 3], 16'h4321);
      mem_wp <= 1'b0;
      repeat (4) @(posedge sys_clk);
      tend("faults");
      cmd(C_UP);
      chk(disp_sig, 16'h1234);
      chk(rcl_dots, 1'b1);
      cmd(C_DN);
      chk(disp_sig, 16'h5678);
      cmd(C_MID);
      chk(rcl_dots, 1'b0);
      meas(16'h5e5e);
      cmd(C_STORE);
      chk(i_ssc_mem_model.mem[A_SIG + 1], 16'h5e5e);
      meas(16'h6f6f);
      cmd(C_STORE);
      chk(i_ssc_mem_model.mem[A_SIG + 2], 16'h6f6f);
      tend("recall");
      // Spoil every active word so the reload has something to undo
      for (int i = 0; i < NSET; i++) begin
         axi_wr(8'(R_SET0 + 4 * i), 32'h9999, rsp);
      end
      cmd(C_ONOFF);
      cmd(C_ONOFF);
      axi_rd(R_STAT, rd, rsp);
      chk(rd[15:8], 8'h01);
      for (int i = 0; i < NSET; i++) begin
         chk(trig_set[16*i +: 16], 16'h1100 + i);
      end
      i_ssc_mem_model.mem[A_LAST] = 16'h7d7d;
      cmd(C_DN);
      chk(disp_sig, 16'h7d7d);
      cmd(C_MID);
      meas(16'h7e7e);
      cmd(C_STORE);
      chk(i_ssc_mem_model.mem[A_LAST], 16'h7e7e);
      axi_rd(R_STAT, rd, rsp);
      chk(rd[ST_FULL], 1'b1);
      meas(16'h7f7f);
      cmd(C_STORE);
      chk(nb1 + nb2, 0);
      chk(i_ssc_mem_model.mem[A_LAST + 1], 16'h0000);
      tend("full");
      axi_rd(8'h40, rd, rsp);
      chk(rsp, RESP_DECERR);
      axi_rd(R_CMD, rd, rsp);
      chk(rsp, RESP_DECERR);
      axi_wr(8'h40, 32'h1, rsp);
      chk(rsp, RESP_DECERR);
      axi_rd(R_DISP, rd, rsp);
      chk({rsp, rd[15:0]}, {RESP_OKAY, 16'h7f7f});
      tend("bus");
      complete_run();
   end
endmodule
